/* File: pkg/ictd_pkg.sv */
package ictd_pkg;
  localparam int          SENSE_W     = 16;
  localparam int          SEL_W       = 4;
  localparam int          SEL_COUNT   = 16;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          SETTLE_NS   = 1000;
  localparam int          SETTLE_CYC  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W       = 8;
  localparam int          OFFSET_SHIFT = 5;
  localparam int          HYST_SHIFT  = 6;
  localparam logic        OUT_RESET   = 1'b0;
  localparam logic        LEVEL_OPEN  = 1'b1;
  localparam logic        LEVEL_CLOSED = 1'b0;
endpackage : ictd_pkg

/* File: pkg/ictd_cmp_if.sv */
interface ictd_cmp_if #(
  parameter int W = 16
);
  logic [W:0] sense;
  logic [W:0] ref_adj;
  logic       valid;
  logic       level;
  logic       done;
  modport src (output sense, output ref_adj, output valid, input level, input done);
  modport cmp (input sense, input ref_adj, input valid, output level, output done);
endinterface : ictd_cmp_if

/* File: core/ictd_hyst_cmp.sv */
module ictd_hyst_cmp
  import ictd_pkg::*;
#(
  parameter int W = SENSE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  ictd_cmp_if.cmp  cmp
);
  typedef struct packed {
    logic level;
    logic done;
  } ictd_cmp_state_type;

  ictd_cmp_state_type st_q;
  ictd_cmp_state_type st_d;
  logic [W+1:0]       lo_thr;
  logic [W+1:0]       hi_thr;
  logic [W+1:0]       sense_x;

  // thresholds around the adjusted reference
  always_comb begin
    sense_x = {1'b0, cmp.sense};
    lo_thr  = {1'b0, cmp.ref_adj} - {1'b0, (cmp.ref_adj >> HYST_SHIFT)};
    hi_thr  = {1'b0, cmp.ref_adj} + {1'b0, (cmp.ref_adj >> HYST_SHIFT)};
  end

  always_comb begin
    st_d      = st_q;
    st_d.done = cmp.valid;
    if (cmp.valid) begin
      if (sense_x < lo_thr) begin
        st_d.level = LEVEL_CLOSED;
      end else if (sense_x > hi_thr) begin
        st_d.level = LEVEL_OPEN;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{level: OUT_RESET, done: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cmp.level = st_q.level;
  assign cmp.done  = st_q.done;

  property p_hold_between;
    @(posedge clk) disable iff (!rst_n)
      cmp.valid && sense_x >= lo_thr && sense_x <= hi_thr |=> cmp.level == $past(cmp.level);
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("level changed inside hysteresis band");
endmodule : ictd_hyst_cmp

/* File: core/ictd_switch.sv */
module ictd_switch
  import ictd_pkg::*;
#(
  parameter int W = SENSE_W
) (
  input  wire logic             MCLK,
  input  wire logic             RESETN,
  input  wire logic             ENABLE,
  input  wire logic [SEL_W-1:0] THRESHOLD_SELECT_INPUT,
  input  wire logic             TWO_COIL,
  input  wire logic             SAMPLE_STROBE,
  input  wire logic [W-1:0]     SENSE_COIL_A,
  input  wire logic [W-1:0]     SENSE_COIL_B,
  input  wire logic [W-1:0]     REFERENCE_COIL,
  output logic                  TAMPER_OUT,
  output logic                  OUT_VALID
);
  typedef struct packed {
    logic             en_s1;
    logic             en_s2;
    logic [SEL_W-1:0] sel_s1;
    logic [SEL_W-1:0] sel_s2;
    logic [CNT_W-1:0] cnt;
    logic             settled;
    logic [W:0]       sense_eq;
    logic [W:0]       ref_adj;
    logic             cvalid;
    logic             out;
    logic             ovalid;
  } ictd_state_type;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC);

  ictd_state_type st_q;
  ictd_state_type st_d;
  logic           take;

  ictd_cmp_if #(.W(W)) cmp_bus ();

  // offset is sel/32 of the reference; sel 0 leaves it untouched
  function automatic logic [W:0] adjust_ref(input logic [W-1:0] r, input logic [SEL_W-1:0] s);
    logic [W+SEL_W-1:0] prod;
    prod = r * s;
    return {1'b0, r} - {1'b0, W'(prod >> OFFSET_SHIFT)};
  endfunction : adjust_ref

  function automatic logic [W:0] sense_sum(input logic two, input logic [W-1:0] a,
                                           input logic [W-1:0] b);
    return two ? ({1'b0, a} + {1'b0, b}) : {1'b0, a};
  endfunction : sense_sum

  assign take = SAMPLE_STROBE && st_q.en_s2 && st_q.settled;

  always_comb begin
    st_d        = st_q;
    st_d.en_s1  = ENABLE;
    st_d.en_s2  = st_q.en_s1;
    st_d.sel_s1 = THRESHOLD_SELECT_INPUT;
    st_d.sel_s2 = st_q.sel_s1;
    st_d.cvalid = 1'b0;
    // settle timer after enable
    if (!st_q.en_s2) begin
      st_d.cnt     = '0;
      st_d.settled = 1'b0;
      st_d.ovalid  = 1'b0;
    end else if (!st_q.settled) begin
      st_d.cnt     = st_q.cnt + CNT_W'(1);
      st_d.settled = (st_q.cnt + CNT_W'(1)) >= SETTLE_LAST;
    end
    if (take) begin
      st_d.sense_eq = sense_sum(TWO_COIL, SENSE_COIL_A, SENSE_COIL_B);
      st_d.ref_adj  = adjust_ref(REFERENCE_COIL, st_q.sel_s2);
      st_d.cvalid   = 1'b1;
    end
    if (cmp_bus.done && st_q.en_s2) begin
      st_d.out    = cmp_bus.level;
      st_d.ovalid = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      st_q <= '{en_s1: 1'b0, en_s2: 1'b0, sel_s1: '0, sel_s2: '0, cnt: '0, settled: 1'b0,
                sense_eq: '0, ref_adj: '0, cvalid: 1'b0, out: OUT_RESET, ovalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cmp_bus.sense   = st_q.sense_eq;
  assign cmp_bus.ref_adj = st_q.ref_adj;
  assign cmp_bus.valid   = st_q.cvalid;
  assign TAMPER_OUT      = st_q.out;
  assign OUT_VALID       = st_q.ovalid;

  ictd_hyst_cmp #(.W(W)) u_cmp (
    .clk   (MCLK),
    .rst_n (RESETN),
    .cmp   (cmp_bus.cmp)
  );

  // checking helpers
  logic [W+1:0] exp_sense;
  logic [W+1:0] exp_lo;
  logic [W+1:0] exp_hi;
  logic [W:0]   exp_ref;
  always_comb begin
    exp_sense = {1'b0, sense_sum(TWO_COIL, SENSE_COIL_A, SENSE_COIL_B)};
    exp_ref   = adjust_ref(REFERENCE_COIL, st_q.sel_s2);
    exp_lo    = {1'b0, exp_ref} - {1'b0, (exp_ref >> HYST_SHIFT)};
    exp_hi    = {1'b0, exp_ref} + {1'b0, (exp_ref >> HYST_SHIFT)};
  end

  property p_closed_low;
    @(posedge MCLK) disable iff (!RESETN)
      take && ENABLE && exp_sense < exp_lo |-> ##3 (TAMPER_OUT == LEVEL_CLOSED);
  endproperty
  a_closed_low: assert property (p_closed_low)
    else $error("output not low for close target");

  property p_open_high;
    @(posedge MCLK) disable iff (!RESETN)
      take && ENABLE && exp_sense > exp_hi |-> ##3 (TAMPER_OUT == LEVEL_OPEN);
  endproperty
  a_open_high: assert property (p_open_high)
    else $error("output not high for far target");

  property p_offset_applied;
    @(posedge MCLK) disable iff (!RESETN)
      take |=> st_q.ref_adj == adjust_ref($past(REFERENCE_COIL), $past(st_q.sel_s2));
  endproperty
  a_offset_applied: assert property (p_offset_applied)
    else $error("reference offset wrong");

  property p_zero_offset;
    @(posedge MCLK) disable iff (!RESETN)
      take && st_q.sel_s2 == '0 |=> st_q.ref_adj == {1'b0, $past(REFERENCE_COIL)};
  endproperty
  a_zero_offset: assert property (p_zero_offset)
    else $error("setting zero altered reference");

  property p_two_coil_sum;
    @(posedge MCLK) disable iff (!RESETN)
      take && TWO_COIL |=>
        st_q.sense_eq == {1'b0, $past(SENSE_COIL_A)} + {1'b0, $past(SENSE_COIL_B)};
  endproperty
  a_two_coil_sum: assert property (p_two_coil_sum)
    else $error("series coils not summed");

  property p_valid_drops;
    @(posedge MCLK) disable iff (!RESETN)
      $fell(st_q.en_s2) |=> !OUT_VALID [*2];
  endproperty
  a_valid_drops: assert property (p_valid_drops)
    else $error("output valid while disabled");

  property p_settle_time;
    @(posedge MCLK) disable iff (!RESETN)
      $rose(st_q.en_s2) |-> !st_q.settled ##20 st_q.settled || !st_q.en_s2;
  endproperty
  a_settle_time: assert property (p_settle_time)
    else $error("settle count wrong");

  property p_hold_disabled;
    @(posedge MCLK) disable iff (!RESETN)
      !st_q.en_s2 |=> $stable(TAMPER_OUT);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("output moved while disabled");

  property p_refuse_unsettled;
    @(posedge MCLK) disable iff (!RESETN)
      SAMPLE_STROBE && !st_q.settled |=> !st_q.cvalid;
  endproperty
  a_refuse_unsettled: assert property (p_refuse_unsettled)
    else $error("strobe taken before settling");

  property p_valid_after_take;
    @(posedge MCLK) disable iff (!RESETN)
      take && ENABLE |-> ##3 OUT_VALID;
  endproperty
  a_valid_after_take: assert property (p_valid_after_take)
    else $error("no valid after sample");

  property p_level_on_done;
    @(posedge MCLK) disable iff (!RESETN)
      !cmp_bus.done |=> $stable(TAMPER_OUT);
  endproperty
  a_level_on_done: assert property (p_level_on_done)
    else $error("output moved without comparison");

  property p_offset_subtracts;
    @(posedge MCLK) disable iff (!RESETN)
      take |=> (st_q.ref_adj <= {1'b0, $past(REFERENCE_COIL)});
  endproperty
  a_offset_subtracts: assert property (p_offset_subtracts)
    else $error("offset raised the reference");

  property p_single_coil;
    @(posedge MCLK) disable iff (!RESETN)
      take && !TWO_COIL |=> st_q.sense_eq == {1'b0, $past(SENSE_COIL_A)};
  endproperty
  a_single_coil: assert property (p_single_coil)
    else $error("single coil word wrong");

  property p_cmp_answers;
    @(posedge MCLK) disable iff (!RESETN)
      cmp_bus.valid |=> cmp_bus.done;
  endproperty
  a_cmp_answers: assert property (p_cmp_answers)
    else $error("comparator gave no answer");

  property p_out_follows_cmp;
    @(posedge MCLK) disable iff (!RESETN)
      cmp_bus.done && st_q.en_s2 |=> TAMPER_OUT == $past(cmp_bus.level);
  endproperty
  a_out_follows_cmp: assert property (p_out_follows_cmp)
    else $error("output differs from comparator");
endmodule : ictd_switch

/* File: tb/ictd_host_model.sv */
module ictd_host_model
  import ictd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wake,
  input  wire logic        level,
  input  wire logic        valid,
  output logic             enable,
  output logic             lamp,
  output logic [63:0]      first_time
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        logged;
  int unsigned held;
  always @(posedge clk) begin
    if (!rst_n) begin
      enable     <= 1'b0;
      lamp       <= 1'b0;
      logged     <= 1'b0;
      first_time <= '0;
      held       <= 0;
    end else begin
      held <= enable ? held + 1 : 0;
      if (wake) begin
        enable <= 1'b1;
      end else if (enable && valid && held > SETTLE_CYC + 2) begin
        enable <= 1'b0;
        lamp   <= level;
        if (level == LEVEL_OPEN && !logged) begin
          logged     <= 1'b1;
          first_time <= $time;
        end
      end
    end
  end
endmodule : ictd_host_model

/* File: tb/case_tamper_inductive_switch_bench.sv */
module case_tamper_inductive_switch_bench
  import ictd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk = 1'b0, resetn = 1'b0, wake = 1'b0, two_coil = 1'b0, strobe = 1'b0;
  logic [SEL_W-1:0]   sel = '0;
  logic [SENSE_W-1:0] coil_a = '0, coil_b = '0, ref_coil = '0;
  logic               enable, tamper, valid, lamp, exp_lvl;
  logic [63:0]        first_time, ft_seen = '0;
  int                 error_cnt = 0, checked = 0, cycles = 0;
  ictd_switch #(.W(SENSE_W)) ictd_switch_i (.MCLK(mclk), .RESETN(resetn), .ENABLE(enable),
    .THRESHOLD_SELECT_INPUT(sel), .TWO_COIL(two_coil), .SAMPLE_STROBE(strobe),
    .SENSE_COIL_A(coil_a), .SENSE_COIL_B(coil_b), .REFERENCE_COIL(ref_coil),
    .TAMPER_OUT(tamper), .OUT_VALID(valid));
  ictd_host_model ictd_host_model_i (.clk(mclk), .rst_n(resetn), .wake(wake), .level(tamper),
    .valid(valid), .enable(enable), .lamp(lamp), .first_time(first_time));
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit
  function automatic logic model(input logic prev, input int s, input int r, input int k);
    int threshold_select_input, hy;
    threshold_select_input = r - ((r * k) >> 5);
    hy  = threshold_select_input >> 6;
    if (s < threshold_select_input - hy) return LEVEL_CLOSED;
    if (s > threshold_select_input + hy) return LEVEL_OPEN;
    return prev;
  endfunction : model
  task automatic sample(input int a, input int b);
    int n;
    coil_a  = a[SENSE_W-1:0];
    coil_b  = b[SENSE_W-1:0];
    exp_lvl = model(exp_lvl, two_coil ? a + b : a, int'(ref_coil), int'(sel));
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    step(SETTLE_CYC + 6);
    strobe = 1'b1;
    step(1);
    strobe = 1'b0;
    n = 0;
    while (enable !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    chk_bit(valid, 1'b1, "valid");
    chk_bit(lamp, exp_lvl, "lamp");
  endtask : sample
  task automatic t_threshold();
    int threshold_select_input, hy;
    int pts[4];
    ref_coil = 16'h1000;
    for (int k = 0; k < SEL_COUNT; k++) begin
      sel = k[SEL_W-1:0];
      threshold_select_input = 4096 - ((4096 * k) >> 5);
      hy  = threshold_select_input >> 6;
      pts = '{threshold_select_input + hy + 1, threshold_select_input - hy, threshold_select_input - hy - 1, threshold_select_input + hy};
      foreach (pts[i]) begin
        sample(pts[i], 0);
        chk_bit(tamper, exp_lvl, "threshold");
        if (ft_seen == '0 && exp_lvl == LEVEL_OPEN) begin
          ft_seen = $time - 1;
        end
      end
    end
    chk_bit(first_time == ft_seen, 1'b1, "first tamper time");
  endtask : t_threshold
  task automatic t_two_coil();
    int pa[5] = '{3000, 5500, 3000, 3000, 5500};
    int pb[5] = '{3000, 3000, 3000, 5500, 5500};
    two_coil = 1'b1;
    sel      = '0;
    ref_coil = 16'h2000;
    foreach (pa[i]) begin
      sample(pa[i], pb[i]);
      chk_bit(tamper, exp_lvl, "two coil");
    end
    chk_bit(first_time == ft_seen, 1'b1, "first tamper kept");
    two_coil = 1'b0;
  endtask : t_two_coil
  task automatic t_refused();
    ref_coil = 16'h1000;
    sample(1000, 0);
    chk_bit(tamper, LEVEL_CLOSED, "closed");
    step(6);
    coil_a = 16'hffff;
    strobe = 1'b1;
    step(1);
    strobe = 1'b0;
    step(6);
    chk_bit(tamper, LEVEL_CLOSED, "disabled level");
    chk_bit(valid, 1'b0, "disabled valid");
  endtask : t_refused
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    exp_lvl = OUT_RESET;
    step(8);
    resetn = 1'b1;
    step(2);
    t_threshold();
    t_two_coil();
    t_refused();
    wrap_up();
  end
endmodule : case_tamper_inductive_switch_bench
